// ===== logic/fcs_regs.svh
// Register map, command words, field positions and timing of the flash command sequencer
`ifndef FCS_REGS_SVH
`define FCS_REGS_SVH
// Byte addresses on the register bus
`define FCS_WIN_LIMIT 12'h200
`define FCS_CMD_ADDR 12'h800
`define FCS_MODE_ADDR 12'h900
`define FCS_STAT_ADDR 12'h904
// Command words
`define FCS_CMD_ARRAY 16'h00ff
`define FCS_CMD_STATUS 16'h0070
`define FCS_CMD_CLEAR 16'h0050
`define FCS_CMD_PROG 16'h0043
`define FCS_CMD_ERASE 16'h0020
`define FCS_CMD_LOCK 16'h0077
`define FCS_CMD_LQUERY 16'h0071
`define FCS_CMD_PROT 16'h0067
`define FCS_CMD_RPROT 16'h0061
`define FCS_CMD_CONFIRM 16'h00d0
// Mode register fields
`define FCS_ACCESS_BIT 0
`define FCS_LQMETHOD_BIT 1
`define FCS_MODE_ONE_BIT 2
`define FCS_FAIL_BIT 3
// Status register and status word fields
`define FCS_RDY_BIT 7
`define FCS_LSTATE_BIT 6
`define FCS_ERASE_ERR_BIT 5
`define FCS_PROG_ERR_BIT 4
// Reset values
`define FCS_ERASED 16'hffff
`define FCS_MODE_RESET 4'h0
// Timing
`define FCS_CLK_NS 20
`define FCS_OP_NS 400
`define FCS_ACCESS_NS 60
`endif

// ===== logic/fcs_pkg.sv
// Types shared by the flash command sequencer modules
package fcs_pkg;
  typedef enum logic [1:0] {RD_ARRAY, RD_STATUS, RD_LOCK, RD_PROT} fcs_mode_t;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT2, ST_PDATA, ST_BUSY} fcs_state_t;
  typedef enum logic [2:0] {OP_PROG, OP_ERASE, OP_LOCK, OP_PROT, OP_QUERY} fcs_op_t;
endpackage

// ===== logic/fcs_bus_if.sv
// Internal access channel between the bus front end and the sequencer core
`timescale 1ns/100ps
interface fcs_bus_if;
  logic wr;
  logic [11:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic err;
  modport front (output wr, output addr, output wdata, input rdata, input err);
  modport core (input wr, input addr, input wdata, output rdata, output err);
endinterface

// ===== logic/fcs_axil.sv
// AXI4-Lite slave front end of the flash command sequencer
`timescale 1ns/100ps
module fcs_axil (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  fcs_bus_if.front bus
);
  logic [11:0] aw_reg, ar_reg;
  logic [15:0] w_reg;
  logic aw_held, w_held, ar_held;
  logic aw_held_next, w_held_next, ar_held_next, bvalid_next, rvalid_next;
  wire aw_take = awvalid && awready;
  wire w_take = wvalid && wready;
  wire ar_take = arvalid && arready;
  // Writes win the core port; a read waits one cycle behind them
  wire wr_fire = aw_held && w_held && !bvalid;
  wire rd_fire = ar_held && !rvalid && !wr_fire;

  // ----------------------------------------
  // Handshake next state
  // ----------------------------------------
  assign aw_held_next = (aw_held || aw_take) && !wr_fire;
  assign w_held_next = (w_held || w_take) && !wr_fire;
  assign ar_held_next = (ar_held || ar_take) && !rd_fire;
  assign bvalid_next = (bvalid && !bready) || wr_fire;
  assign rvalid_next = (rvalid && !rready) || rd_fire;
  assign bus.wr = wr_fire;
  assign bus.addr = wr_fire ? aw_reg : ar_reg;
  assign bus.wdata = w_reg;

  // Channel registers; ready is precomputed so it leaves a flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      ar_held <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      arready <= 1'b0;
      bvalid <= 1'b0;
      rvalid <= 1'b0;
      bresp <= 2'h0;
      rresp <= 2'h0;
      rdata <= 32'h0000_0000;
      aw_reg <= 12'h000;
      ar_reg <= 12'h000;
      w_reg <= 16'h0000;
    end else begin
      aw_held <= aw_held_next;
      w_held <= w_held_next;
      ar_held <= ar_held_next;
      awready <= !aw_held_next && !bvalid_next;
      wready <= !w_held_next && !bvalid_next;
      arready <= !ar_held_next && !rvalid_next;
      bvalid <= bvalid_next;
      rvalid <= rvalid_next;
      if (aw_take) aw_reg <= awaddr;
      if (w_take) w_reg <= wdata[15:0];
      if (ar_take) ar_reg <= araddr;
      // Unmapped addresses answer SLVERR
      if (wr_fire) bresp <= bus.err ? 2'h2 : 2'h0;
      if (rd_fire) begin
        rresp <= bus.err ? 2'h2 : 2'h0;
        rdata <= {16'h0000, bus.rdata};
      end
    end
  end
endmodule

// ===== logic/fcs_top.sv
// Flash command sequencer: command decode, read modes, automatic operations, status
//
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "fcs_regs.svh"
module fcs_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // Least times round up to whole cycles
  localparam int OP_CYC = (`FCS_OP_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS;
  localparam int ACCESS_CYC = (`FCS_ACCESS_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS;

  fcs_bus_if bus ();

  fcs_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .bus(bus.front)
  );

  // ----------------------------------------
  // Address helpers
  // ----------------------------------------
  // Flash halfword index and 32-halfword block of a bus address
  function automatic logic [6:0] fcs_word(input logic [11:0] a);
    return a[8:2];
  endfunction
  function automatic logic [1:0] fcs_blk(input logic [11:0] a);
    return a[8:7];
  endfunction

  logic [15:0] mem [0:127];
  logic [3:0] lock_bits_reg, prot_bits_reg;
  logic [15:0] pbuf_reg [0:3];
  logic [4:0] pbase_reg;
  logic [1:0] pcnt_reg, blk_reg;
  logic [7:0] cnt_reg;
  logic [3:0] access_cnt_reg;
  fcs_pkg::fcs_state_t state_reg;
  fcs_pkg::fcs_mode_t mode_reg;
  fcs_pkg::fcs_op_t op_reg;
  logic erase_err_reg, prog_err_reg, lock_state_reg, lock_method_reg, mode_one_reg, fail_reg;

  // ----------------------------------------
  // Access decode
  // ----------------------------------------
  wire in_win = bus.addr < `FCS_WIN_LIMIT;
  wire is_cmd = bus.addr == `FCS_CMD_ADDR;
  wire is_mode = bus.addr == `FCS_MODE_ADDR;
  wire is_stat = bus.addr == `FCS_STAT_ADDR;
  // Byte strobes are not decoded: every write carries a full halfword
  wire wr_any = bus.wr;
  wire cmd_wr = wr_any && is_cmd && state_reg == fcs_pkg::ST_IDLE;
  wire [15:0] wd = bus.wdata;
  wire [1:0] ablk = fcs_blk(bus.addr);
  wire [6:0] aword = fcs_word(bus.addr);
  wire rdy = state_reg != fcs_pkg::ST_BUSY;
  wire access_busy = access_cnt_reg != 4'h0;
  wire done = state_reg == fcs_pkg::ST_BUSY && cnt_reg == 8'h00;
  wire blk_locked = !lock_bits_reg[blk_reg];
  // Second cycle of erase, lock, query or protect
  wire w2_wr = wr_any && state_reg == fcs_pkg::ST_WAIT2;
  wire w2_cancel = w2_wr && wd == `FCS_CMD_ARRAY;
  wire w2_bad = w2_wr && !w2_cancel && (wd != `FCS_CMD_CONFIRM || !in_win);
  wire w2_go = w2_wr && !w2_cancel && !w2_bad;
  // Program data cycles must walk halfwords 0,1,2,3 inside one aligned group
  wire pd_wr = wr_any && state_reg == fcs_pkg::ST_PDATA;
  wire pd_ok = in_win && aword[1:0] == pcnt_reg
    && (pcnt_reg == 2'h0 || aword[6:2] == pbase_reg);
  wire seq_err = w2_bad || (pd_wr && !pd_ok);

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Mode one pins the read mode to array regardless of commands
  // array under mode one
  wire [1:0] eff_mode = mode_one_reg ? 2'(fcs_pkg::RD_ARRAY) : 2'(mode_reg);
  wire [15:0] stat_word = 16'(rdy) << `FCS_RDY_BIT | 16'(erase_err_reg) << `FCS_ERASE_ERR_BIT
    | 16'(prog_err_reg) << `FCS_PROG_ERR_BIT;
  wire [15:0] lock_word = 16'(lock_bits_reg[ablk]) << `FCS_LSTATE_BIT;
  wire [15:0] prot_word = 16'(prot_bits_reg[ablk]) << `FCS_LSTATE_BIT;
  wire [15:0] mode_word = 16'({fail_reg, mode_one_reg, lock_method_reg, access_busy});
  wire [15:0] win_word = eff_mode == 2'(fcs_pkg::RD_STATUS) ? stat_word
    : eff_mode == 2'(fcs_pkg::RD_LOCK) ? lock_word
    : eff_mode == 2'(fcs_pkg::RD_PROT) ? prot_word : mem[aword];
  // array, status, lock and protect reads
  assign bus.rdata = in_win ? win_word
    : is_mode ? mode_word
    : is_stat ? (stat_word | 16'(lock_state_reg) << `FCS_LSTATE_BIT) : 16'h0000;
  assign bus.err = !(in_win || is_cmd || is_mode || is_stat);

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= fcs_pkg::ST_IDLE;
      mode_reg <= fcs_pkg::RD_ARRAY;
      op_reg <= fcs_pkg::OP_PROG;
      cnt_reg <= 8'h00;
      pcnt_reg <= 2'h0;
      blk_reg <= 2'h0;
    end else begin
      case (state_reg)
        fcs_pkg::ST_IDLE: begin
          if (cmd_wr) begin
            if (wd == `FCS_CMD_ARRAY) mode_reg <= fcs_pkg::RD_ARRAY;
            else if (wd == `FCS_CMD_STATUS) mode_reg <= fcs_pkg::RD_STATUS;
            else if (wd == `FCS_CMD_RPROT) mode_reg <= fcs_pkg::RD_PROT;
            else if (wd == `FCS_CMD_LQUERY && !lock_method_reg) mode_reg <= fcs_pkg::RD_LOCK;
            else if (wd == `FCS_CMD_PROG) begin
              state_reg <= fcs_pkg::ST_PDATA;
              pcnt_reg <= 2'h0;
            end else if (wd == `FCS_CMD_ERASE || wd == `FCS_CMD_LOCK
                || wd == `FCS_CMD_PROT || wd == `FCS_CMD_LQUERY) begin
              state_reg <= fcs_pkg::ST_WAIT2;
              op_reg <= wd == `FCS_CMD_ERASE ? fcs_pkg::OP_ERASE
                : wd == `FCS_CMD_LOCK ? fcs_pkg::OP_LOCK
                : wd == `FCS_CMD_PROT ? fcs_pkg::OP_PROT : fcs_pkg::OP_QUERY;
            end
          end
        end
        fcs_pkg::ST_WAIT2: begin
          if (w2_cancel) begin
            state_reg <= fcs_pkg::ST_IDLE;
            mode_reg <= fcs_pkg::RD_ARRAY;
          end else if (w2_bad) begin
            state_reg <= fcs_pkg::ST_IDLE;
          end else if (w2_go) begin
            // confirmed: start on the addressed block
            state_reg <= fcs_pkg::ST_BUSY;
            blk_reg <= ablk;
            cnt_reg <= 8'(OP_CYC - 1);
          end
        end
        fcs_pkg::ST_PDATA: begin
          if (pd_wr && !pd_ok) begin
            state_reg <= fcs_pkg::ST_IDLE;
          end else if (pd_wr) begin
            pcnt_reg <= pcnt_reg + 2'h1;
            blk_reg <= ablk;
            if (pcnt_reg == 2'h3) begin
              state_reg <= fcs_pkg::ST_BUSY;
              op_reg <= fcs_pkg::OP_PROG;
              cnt_reg <= 8'(OP_CYC - 1);
            end
          end
        end
        fcs_pkg::ST_BUSY: begin
          cnt_reg <= cnt_reg - 8'h01;
          if (done) begin
            state_reg <= fcs_pkg::ST_IDLE;
            mode_reg <= mode_one_reg ? fcs_pkg::RD_ARRAY : fcs_pkg::RD_STATUS;
          end
        end
        default: state_reg <= fcs_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Status flags and mode register
  // ----------------------------------------
  // Clear and set never meet: clear is taken only while idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      erase_err_reg <= 1'b0;
      prog_err_reg <= 1'b0;
      lock_state_reg <= 1'b0;
      {fail_reg, mode_one_reg, lock_method_reg} <= 3'(`FCS_MODE_RESET);
      access_cnt_reg <= 4'h0;
    end else begin
      if (wr_any && is_mode) begin
        lock_method_reg <= wd[`FCS_LQMETHOD_BIT];
        mode_one_reg <= wd[`FCS_MODE_ONE_BIT];
        fail_reg <= wd[`FCS_FAIL_BIT];
      end
      // Flag stays up a short while after each command cycle
      if (cmd_wr || pd_wr || w2_wr) access_cnt_reg <= 4'(ACCESS_CYC);
      else if (access_busy) access_cnt_reg <= access_cnt_reg - 4'h1;
      if (cmd_wr && wd == `FCS_CMD_CLEAR) begin
        erase_err_reg <= 1'b0;
        prog_err_reg <= 1'b0;
      end
      if (seq_err) begin
        erase_err_reg <= 1'b1;
        prog_err_reg <= 1'b1;
      end
      if (done) begin
        if (op_reg == fcs_pkg::OP_ERASE && (blk_locked || fail_reg)) erase_err_reg <= 1'b1;
        if ((op_reg == fcs_pkg::OP_PROG && blk_locked)
            || (fail_reg && op_reg != fcs_pkg::OP_ERASE && op_reg != fcs_pkg::OP_QUERY)) begin
          prog_err_reg <= 1'b1;
        end
        if (op_reg == fcs_pkg::OP_QUERY) lock_state_reg <= lock_bits_reg[blk_reg];
      end
    end
  end

  // ----------------------------------------
  // Flash array, lock and protect bits
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_bits_reg <= 4'hf;
      prot_bits_reg <= 4'hf;
      pbase_reg <= 5'h00;
      for (int i = 0; i < 128; i++) mem[i] <= `FCS_ERASED;
    end else begin
      if (pd_wr && pd_ok) begin
        pbuf_reg[pcnt_reg] <= wd;
        if (pcnt_reg == 2'h0) pbase_reg <= aword[6:2];
      end
      if (done && !fail_reg) begin
        if (op_reg == fcs_pkg::OP_PROG && !blk_locked) begin
          for (int k = 0; k < 4; k++) mem[{pbase_reg, 2'(k)}] <= pbuf_reg[k];
        end
        if (op_reg == fcs_pkg::OP_ERASE && !blk_locked) begin
          for (int k = 0; k < 32; k++) mem[{blk_reg, 5'(k)}] <= `FCS_ERASED;
        end
        if (op_reg == fcs_pkg::OP_LOCK) lock_bits_reg[blk_reg] <= 1'b0;
        if (op_reg == fcs_pkg::OP_PROT) prot_bits_reg[blk_reg] <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_seq_error: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_err |=> erase_err_reg && prog_err_reg) else $error("sequence error not flagged");
  a_clear_status: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_wr && wd == `FCS_CMD_CLEAR |=> !erase_err_reg && !prog_err_reg)
    else $error("clear status failed");
  a_busy_ends: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(!rdy) |-> !rdy ##[1:OP_CYC] rdy) else $error("busy length wrong");
  a_done_mode: assert property (@(posedge aclk) disable iff (!aresetn)
    done |=> mode_reg == ($past(mode_one_reg) ? fcs_pkg::RD_ARRAY : fcs_pkg::RD_STATUS))
    else $error("mode after operation wrong");
  a_mode_one_array: assert property (@(posedge aclk) disable iff (!aresetn)
    mode_one_reg && in_win |-> bus.rdata == mem[aword]) else $error("mode one read not array");
  a_status_read: assert property (@(posedge aclk) disable iff (!aresetn)
    !mode_one_reg && mode_reg == fcs_pkg::RD_STATUS && in_win |-> bus.rdata[7] == rdy)
    else $error("status read wrong");
  a_erase_locked: assert property (@(posedge aclk) disable iff (!aresetn)
    done && op_reg == fcs_pkg::OP_ERASE && blk_locked |=> erase_err_reg)
    else $error("locked erase not flagged");
  a_prog_locked: assert property (@(posedge aclk) disable iff (!aresetn)
    done && op_reg == fcs_pkg::OP_PROG && blk_locked |=> prog_err_reg)
    else $error("locked program not flagged");
  a_lock_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    done && op_reg == fcs_pkg::OP_LOCK && !fail_reg |=> !lock_bits_reg[$past(blk_reg)])
    else $error("lock bit not cleared");
endmodule

// ===== test/fcs_cpu_model.sv
// Processor model issuing flash rewrite commands over AXI4-Lite
`timescale 1ns/100ps
`include "fcs_regs.svh"
module fcs_cpu_model (
  input wire logic aclk,
  output logic [11:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [11:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  logic [15:0] st;
  logic [1:0] rs;
  logic [1:0] wresp;
  // --------------------------------------------
  // Bus cycles
  // --------------------------------------------
  // Idle bus at time zero; halfword writes always carry all strobes
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
  end
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {16'h0000, d};
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    wresp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  // Extra edge at the end keeps rready from toggling twice in one step
  task automatic rd(input logic [11:0] a, output logic [15:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata[15:0];
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic wait_rdy();
    do rd(`FCS_STAT_ADDR, st, rs); while (st[7] !== 1'b1);
  endtask
  task automatic cmd(input logic [15:0] w);
    wait_rdy();
    wr(`FCS_CMD_ADDR, w);
  endtask
  task automatic last(input logic [11:0] a, input logic [15:0] w);
    do rd(`FCS_MODE_ADDR, st, rs); while (st[0] !== 1'b0);
    wr(a, w);
  endtask
  // four halfwords into an erased group
  task automatic prog(input logic [11:0] b, input logic [63:0] d);
    cmd(`FCS_CMD_PROG);
    for (int i = 0; i < 3; i++) wr(b + 12'(4 * i), d[16*i +: 16]);
    last(b + 12'h00c, d[63:48]);
  endtask
endmodule

// ===== test/flash_command_sequencer_tb.sv
// Self-checking bench for the flash command sequencer
`timescale 1ns/100ps
`include "fcs_regs.svh"
module flash_command_sequencer_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  integer seed = 36;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [63:0] pd;
  logic [15:0] d;
  logic [1:0] r;
  fcs_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  fcs_cpu_model i_cpu (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  // --------------------------------------------
  // Clock, timeout and checking helpers
  // --------------------------------------------
  always #10 aclk = ~aclk;
  // A hung handshake would otherwise stall the run forever
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (bad_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected data at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected resp at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Ready set, lock state bit clear, erase and program flags as given
  function automatic logic [15:0] exp_st(input logic e, input logic p);
    return {8'h00, 1'b1, 1'b0, e, p, 4'h0};
  endfunction
  task automatic rdc(input logic [11:0] a, input logic [15:0] m, input logic [15:0] e);
    logic [15:0] v;
    logic [1:0] rr;
    i_cpu.rd(a, v, rr);
    chk_resp(rr, 2'b00);
    chk_data(v & m, e);
  endtask
  // --------------------------------------------
  // Main sequence
  // --------------------------------------------
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdc(`FCS_STAT_ADDR, 16'h00b0, exp_st(0, 0));
    rdc(`FCS_MODE_ADDR, 16'h000f, 16'h0000);
    rdc(12'h000, 16'hffff, `FCS_ERASED);
    i_cpu.rd(12'h500, d, r);
    chk_resp(r, 2'b10);
    // Random groups in block 3, busy seen, then status mode on completion
    for (int g = 0; g < 3; g++) begin
      pd = {$random(seed), $random(seed)};
      i_cpu.prog(12'h180 + 12'(16 * g), pd);
      i_cpu.rd(`FCS_STAT_ADDR, d, r);
      chk_data(d & 16'h0080, 16'h0000);
      i_cpu.wait_rdy();
      rdc(12'h040, 16'h00b0, exp_st(0, 0));
      i_cpu.cmd(`FCS_CMD_ARRAY);
      for (int k = 0; k < 4; k++) rdc(12'h180 + 12'(16 * g + 4 * k), 16'hffff, pd[16*k +: 16]);
    end
    i_cpu.cmd(`FCS_CMD_ERASE);
    i_cpu.last(12'h1a4, `FCS_CMD_CONFIRM);
    i_cpu.wait_rdy();
    rdc(12'h000, 16'h00b0, exp_st(0, 0));
    i_cpu.cmd(`FCS_CMD_ARRAY);
    for (int g = 0; g < 3; g++) rdc(12'h180 + 12'(16 * g), 16'hffff, `FCS_ERASED);
    // Cancel word in the second cycle leaves no error
    i_cpu.cmd(`FCS_CMD_ERASE);
    i_cpu.last(12'h000, `FCS_CMD_ARRAY);
    rdc(`FCS_STAT_ADDR, 16'h00b0, exp_st(0, 0));
    // Lock block 1, read it back on the data bus, then hit it
    i_cpu.cmd(`FCS_CMD_LOCK);
    i_cpu.last(12'h080, `FCS_CMD_CONFIRM);
    i_cpu.cmd(`FCS_CMD_LQUERY);
    rdc(12'h084, 16'h0040, 16'h0000);
    rdc(12'h000, 16'h0040, 16'h0040);
    i_cpu.cmd(`FCS_CMD_ARRAY);
    i_cpu.prog(12'h080, {$random(seed), $random(seed)});
    i_cpu.wait_rdy();
    rdc(`FCS_STAT_ADDR, 16'h00b0, exp_st(0, 1));
    i_cpu.cmd(`FCS_CMD_CLEAR);
    rdc(`FCS_STAT_ADDR, 16'h00b0, exp_st(0, 0));
    i_cpu.cmd(`FCS_CMD_ERASE);
    i_cpu.last(12'h080, `FCS_CMD_CONFIRM);
    i_cpu.wait_rdy();
    rdc(`FCS_STAT_ADDR, 16'h00b0, exp_st(1, 0));
    i_cpu.cmd(`FCS_CMD_ARRAY);
    rdc(12'h080, 16'hffff, `FCS_ERASED);
    i_cpu.cmd(`FCS_CMD_CLEAR);
    // Query through the status register instead of the data bus
    i_cpu.wr(`FCS_MODE_ADDR, 16'h0002);
    chk_resp(i_cpu.wresp, 2'b00);
    for (int b = 0; b < 2; b++) begin
      i_cpu.cmd(`FCS_CMD_LQUERY);
      i_cpu.last(12'(128 * b), `FCS_CMD_CONFIRM);
      i_cpu.wait_rdy();
      rdc(`FCS_STAT_ADDR, 16'h0040, (b == 0) ? 16'h0040 : 16'h0000);
    end
    i_cpu.wr(`FCS_MODE_ADDR, 16'h0000);
    i_cpu.cmd(`FCS_CMD_PROT);
    i_cpu.last(12'h108, `FCS_CMD_CONFIRM);
    i_cpu.cmd(`FCS_CMD_RPROT);
    rdc(12'h10c, 16'h0040, 16'h0000);
    rdc(12'h180, 16'h0040, 16'h0040);
    // Bad second word, then an address outside the window
    i_cpu.cmd(`FCS_CMD_ERASE);
    i_cpu.last(12'h000, 16'h1234);
    rdc(`FCS_STAT_ADDR, 16'h00b0, exp_st(1, 1));
    i_cpu.cmd(`FCS_CMD_STATUS);
    rdc(12'h040, 16'h00b0, exp_st(1, 1));
    i_cpu.cmd(`FCS_CMD_CLEAR);
    i_cpu.cmd(`FCS_CMD_STATUS);
    rdc(12'h040, 16'h00b0, exp_st(0, 0));
    i_cpu.cmd(`FCS_CMD_ERASE);
    i_cpu.last(12'h600, `FCS_CMD_CONFIRM);
    chk_resp(i_cpu.wresp, 2'b10);
    rdc(`FCS_STAT_ADDR, 16'h00b0, exp_st(1, 1));
    // Program data out of order is a sequence error as well
    i_cpu.cmd(`FCS_CMD_CLEAR);
    i_cpu.cmd(`FCS_CMD_PROG);
    i_cpu.wr(12'h1c4, 16'h5a5a);
    rdc(`FCS_STAT_ADDR, 16'h00b0, exp_st(1, 1));
    // Injected failures of an erase and a lock bit program
    for (int i = 0; i < 2; i++) begin
      i_cpu.cmd(`FCS_CMD_CLEAR);
      i_cpu.wr(`FCS_MODE_ADDR, 16'h0008);
      i_cpu.cmd((i == 0) ? `FCS_CMD_ERASE : `FCS_CMD_LOCK);
      i_cpu.last(12'h000, `FCS_CMD_CONFIRM);
      i_cpu.wait_rdy();
      rdc(`FCS_STAT_ADDR, 16'h00b0, exp_st(i == 0, i == 1));
    end
    // Mode one: array data straight after the operation
    i_cpu.cmd(`FCS_CMD_CLEAR);
    i_cpu.wr(`FCS_MODE_ADDR, 16'h0004);
    pd = {$random(seed), $random(seed)};
    i_cpu.prog(12'h190, pd);
    i_cpu.wait_rdy();
    for (int k = 0; k < 4; k++) rdc(12'h190 + 12'(4 * k), 16'hffff, pd[16*k +: 16]);
    finish_test();
  end
endmodule
